// ### rtl/dsr_core.sv
// Per-channel DMA control: sync event select, interrupt sharing,
// autoinit reload sets, core-to-core FIFO and interprocessor request.
// Assumes one CPU clock, the peer on the same clock, and a DMA engine
// that reports block completion per channel and element accesses on one shared port.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`include "dsr_map.svh"

module dsr_core
    import dsr_pkg::*;
#(
    parameter int CH_NUM = `DSR_CH_NUM,
    parameter int DEPTH  = `DSR_FIFO_DEPTH,
    parameter int AW     = `DSR_FIFO_AW
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    // Register port
    input  wire logic [5:0]        i_addr,
    input  wire logic [15:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [15:0]       o_rdata,
    // Interrupt
    output logic                   o_irq,
    // Serial port events and interrupts
    input  wire dsr_ser_t          i_ser_evt,
    input  wire dsr_ser_t          i_ser_irq,
    // DMA engine side
    input  wire logic [CH_NUM-1:0] i_ch_done,
    input  wire logic [CH_NUM-1:0] i_ch_auto,
    input  wire logic [CH_NUM-1:0] i_ch_global,
    input  wire dsr_acc_t          i_acc,
    output logic      [CH_NUM-1:0] o_ch_go,
    output logic      [CH_NUM-1:0] o_ch_enable,
    output logic      [CH_NUM-1:0] o_ch_prio,
    output logic                   o_free_run,
    output logic      [CH_NUM-1:0] o_ch_peer_mem,
    output logic      [15:0]       o_acc_rdata,
    output logic                   o_acc_ext,
    // Peer subsystem
    input  wire logic [15:0]       i_peer_data,
    input  wire logic              i_peer_valid,
    output logic                   o_peer_ready,
    output logic      [15:0]       o_peer_data,
    output logic                   o_peer_valid,
    input  wire logic              i_peer_ready,
    input  wire logic              i_peer_ipreq,
    output logic                   o_peer_ipreq
);

    logic [15:0]       prec;
    logic [15:0]       interrupt_flag_reg;
    logic [15:0]       interrupt_mask_reg;
    logic [3:0]        sync_sel [CH_NUM];
    dsr_set_t          rel      [CH_NUM];
    dsr_set_t          cur      [CH_NUM];
    logic [15:0]       in_mem   [DEPTH];
    logic [AW:0]       in_wp;
    logic [AW:0]       in_rp;
    logic [15:0]       out_mem  [DEPTH];
    logic [AW:0]       out_wp;
    logic [AW:0]       out_rp;
    logic              in_ne;
    logic              out_nf;
    logic              io_acc;
    logic              in_pop;
    logic              out_push;
    logic [1:0]        isel;
    logic [15:0]       next_ifr_set;
    logic [15:0]       next_rdata;
    logic              wr_ifr_rd;

    // Sync code to event; codes above 8 match nothing
    function automatic logic sync_ok(input logic [3:0] code,
                                     input dsr_ser_t ev,
                                     input logic ne, input logic nf);
        case (code)
            4'h0:    sync_ok = 1'b1;
            4'h1:    sync_ok = ev.rx[0];
            4'h2:    sync_ok = ev.tx[0];
            4'h3:    sync_ok = ev.rx[2];
            4'h4:    sync_ok = ev.tx[2];
            4'h5:    sync_ok = ev.rx[1];
            4'h6:    sync_ok = ev.tx[1];
            4'h7:    sync_ok = ne;
            4'h8:    sync_ok = nf;
            default: sync_ok = 1'b0;
        endcase
    endfunction : sync_ok

    function automatic logic [AW:0] ptr_inc(input logic [AW:0] p);
        ptr_inc = p + {{AW{1'b0}}, 1'b1};
    endfunction : ptr_inc

    assign isel   = prec[`DSR_PREC_ISEL_LO +: 2];
    assign in_ne  = (in_wp != in_rp);
    assign out_nf = (out_wp[AW-1:0] != out_rp[AW-1:0])
                    || (out_wp[AW] == out_rp[AW]);
    // Any DMA I/O space access goes to the FIFOs, never to external I/O
    assign io_acc   = i_acc.req && i_acc.space == DSR_SPACE_IO;
    assign in_pop   = io_acc && !i_acc.wr && in_ne;
    assign out_push = io_acc && i_acc.wr && out_nf;
    assign o_acc_ext = 1'b0;

    assign o_free_run    = prec[`DSR_PREC_FREE];
    assign o_ch_prio     = prec[`DSR_PREC_PRIO_LO +: CH_NUM];
    assign o_ch_enable   = prec[`DSR_PREC_EN_LO +: CH_NUM];
    assign o_ch_peer_mem = i_ch_global;
    assign o_irq         = |(interrupt_flag_reg & interrupt_mask_reg);

    always_comb begin
        for (int c = 0; c < CH_NUM; c++) begin
            o_ch_go[c] = o_ch_enable[c]
                         && sync_ok(sync_sel[c], i_ser_evt, in_ne, out_nf);
        end
    end

    // Interrupt sources routed onto flag positions
    always_comb begin
        next_ifr_set = 16'h0000;
        if (isel == `DSR_ISEL_DMA) begin
            next_ifr_set[`DSR_IF_SHARE0] = i_ch_done[0];
            next_ifr_set[`DSR_IF_SHARE1] = i_ch_done[1];
        end else begin
            next_ifr_set[`DSR_IF_SHARE0] = i_ser_irq.rx[2];
            next_ifr_set[`DSR_IF_SHARE1] = i_ser_irq.tx[2];
        end
        if (isel == `DSR_ISEL_DMA || isel == `DSR_ISEL_HALF) begin
            next_ifr_set[`DSR_IF_SHARE2] = i_ch_done[2];
            next_ifr_set[`DSR_IF_SHARE3] = i_ch_done[3];
        end else if (isel == `DSR_ISEL_SERIAL) begin
            next_ifr_set[`DSR_IF_SHARE2] = i_ser_irq.rx[1];
            next_ifr_set[`DSR_IF_SHARE3] = i_ser_irq.tx[1];
        end
        next_ifr_set[`DSR_IF_CH4] = i_ch_done[4];
        next_ifr_set[`DSR_IF_CH5] = i_ch_done[5];
        next_ifr_set[`DSR_IF_PEER] = i_peer_ipreq;
    end

    // Register read mux
    always_comb begin
        next_rdata = 16'h0000;
        if (i_addr == `DSR_A_PREC) begin
            next_rdata = prec;
        end else if (i_addr == `DSR_A_BANK_SWITCH_CONTROL_REG) begin
            next_rdata = 16'h0000;
        end else if (i_addr == `DSR_A_IFR) begin
            next_rdata = interrupt_flag_reg;
        end else if (i_addr == `DSR_A_IMR) begin
            next_rdata = interrupt_mask_reg;
        end else begin
            for (int c = 0; c < CH_NUM; c++) begin
                if (i_addr == `DSR_A_SYNC0 + 6'(c)) begin
                    next_rdata = {12'h000, sync_sel[c]};
                end else if (i_addr == `DSR_A_RSA0 + 6'(c)) begin
                    next_rdata = rel[c].src;
                end else if (i_addr == `DSR_A_RDA0 + 6'(c)) begin
                    next_rdata = rel[c].dst;
                end else if (i_addr == `DSR_A_REC0 + 6'(c)) begin
                    next_rdata = rel[c].elem;
                end else if (i_addr == `DSR_A_RFC0 + 6'(c)) begin
                    next_rdata = rel[c].frame;
                end else if (i_addr == `DSR_A_CUR0 + 6'(c)) begin
                    next_rdata = cur[c].elem;
                end
            end
        end
    end

    assign wr_ifr_rd = i_rd && (i_addr == `DSR_A_IFR);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= i_rd ? next_rdata : 16'h0000;
        end
    end

    // Priority and enable register; reserved share code 11 is kept
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prec <= `DSR_PREC_RESET;
        end else if (i_wr && i_addr == `DSR_A_PREC) begin
            prec <= i_wdata;
        end
    end

    // Flags: sticky, cleared by read; a new event wins over the clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            interrupt_flag_reg <= 16'h0000;
        end else begin
            interrupt_flag_reg <= (wr_ifr_rd ? 16'h0000 : interrupt_flag_reg) | next_ifr_set;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            interrupt_mask_reg <= 16'h0000;
        end else if (i_wr && i_addr == `DSR_A_IMR) begin
            interrupt_mask_reg <= i_wdata;
        end
    end

    // Interprocessor request pulse to the peer
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_peer_ipreq <= 1'b0;
        end else begin
            o_peer_ipreq <= i_wr && i_addr == `DSR_A_BANK_SWITCH_CONTROL_REG
                            && i_wdata[`DSR_BANK_SWITCH_CONTROL_REG_IPREQ];
        end
    end

    // Sync selects and reload sets, written from the register port
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int c = 0; c < CH_NUM; c++) begin
                sync_sel[c] <= `DSR_SYN_NONE;
                rel[c]      <= '0;
            end
        end else if (i_wr) begin
            for (int c = 0; c < CH_NUM; c++) begin
                if (i_addr == `DSR_A_SYNC0 + 6'(c)) begin
                    sync_sel[c] <= i_wdata[3:0];
                end else if (i_addr == `DSR_A_RSA0 + 6'(c)) begin
                    rel[c].src <= i_wdata;
                end else if (i_addr == `DSR_A_RDA0 + 6'(c)) begin
                    rel[c].dst <= i_wdata;
                end else if (i_addr == `DSR_A_REC0 + 6'(c)) begin
                    rel[c].elem <= i_wdata;
                end else if (i_addr == `DSR_A_RFC0 + 6'(c)) begin
                    rel[c].frame <= i_wdata;
                end
            end
        end
    end

    // Working set only changes at block completion with autoinit
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int c = 0; c < CH_NUM; c++) begin
                cur[c] <= '0;
            end
        end else begin
            for (int c = 0; c < CH_NUM; c++) begin
                if (i_ch_done[c] && i_ch_auto[c]) begin
                    cur[c] <= prec[`DSR_PREC_AUTOSEL] ? rel[c]
                                                     : rel[0];
                end
            end
        end
    end

    // Input FIFO, filled by the peer, drained by DMA I/O reads
    assign o_peer_ready = !((in_wp[AW-1:0] == in_rp[AW-1:0])
                            && (in_wp[AW] != in_rp[AW]));
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            in_wp <= '0;
        end else if (i_peer_valid && o_peer_ready) begin
            in_mem[in_wp[AW-1:0]] <= i_peer_data;
            in_wp <= ptr_inc(in_wp);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            in_rp       <= '0;
            o_acc_rdata <= 16'h0000;
        end else if (in_pop) begin
            o_acc_rdata <= in_mem[in_rp[AW-1:0]];
            in_rp       <= ptr_inc(in_rp);
        end
    end

    // Output FIFO, filled by DMA I/O writes, drained by the peer
    assign o_peer_valid = (out_wp != out_rp);
    assign o_peer_data  = out_mem[out_rp[AW-1:0]];
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_wp <= '0;
        end else if (out_push) begin
            out_mem[out_wp[AW-1:0]] <= i_acc.data;
            out_wp <= ptr_inc(out_wp);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            out_rp <= '0;
        end else if (o_peer_valid && i_peer_ready) begin
            out_rp <= ptr_inc(out_rp);
        end
    end

endmodule : dsr_core

// ### inc/dsr_map.svh
// Register offsets, field positions, reset values and codes of the DMA
// sync, interrupt share, reload and core-to-core FIFO block.
// Assumes a 16-bit CPU register port with word addresses.
`ifndef DSR_MAP_SVH
`define DSR_MAP_SVH

`define DSR_CH_NUM          6
`define DSR_FIFO_DEPTH      8
`define DSR_FIFO_AW         3

// Register word addresses
`define DSR_A_PREC          6'h00
`define DSR_A_BANK_SWITCH_CONTROL_REG          6'h01
`define DSR_A_IFR           6'h02
`define DSR_A_IMR           6'h03
`define DSR_A_SYNC0         6'h08
`define DSR_A_RSA0          6'h10
`define DSR_A_RDA0          6'h18
`define DSR_A_REC0          6'h20
`define DSR_A_RFC0          6'h28
`define DSR_A_CUR0          6'h30

// Priority and enable register fields
`define DSR_PREC_FREE       15
`define DSR_PREC_AUTOSEL    14
`define DSR_PREC_PRIO_LO    8
`define DSR_PREC_ISEL_LO    6
`define DSR_PREC_EN_LO      0
`define DSR_PREC_RESET      16'h0000

// Bank switch control: interprocessor request
`define DSR_BANK_SWITCH_CONTROL_REG_IPREQ      8

// Interrupt flag positions
`define DSR_IF_SHARE0       6
`define DSR_IF_SHARE1       7
`define DSR_IF_SHARE2       10
`define DSR_IF_SHARE3       11
`define DSR_IF_CH4          12
`define DSR_IF_CH5          13
`define DSR_IF_PEER         14

// Sync select codes
`define DSR_SYN_NONE        4'h0
`define DSR_SYN_FIFO_IN     4'h7
`define DSR_SYN_FIFO_OUT    4'h8

// Interrupt share select values
`define DSR_ISEL_SERIAL     2'h0
`define DSR_ISEL_HALF       2'h1
`define DSR_ISEL_DMA        2'h2

`endif

// ### inc/dsr_pkg.sv
// Types of the DMA sync, interrupt share and reload block.
// Assumes dsr_map.svh holds the numeric constants.
package dsr_pkg;

    // One DMA element access as seen by this block
    typedef struct packed {
        logic        req;
        logic        wr;
        logic [1:0]  space;
        logic [15:0] data;
    } dsr_acc_t;

    // Serial port events, receive then transmit per port
    typedef struct packed {
        logic [2:0] rx;
        logic [2:0] tx;
    } dsr_ser_t;

    // Reload set of one channel
    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] elem;
        logic [15:0] frame;
    } dsr_set_t;

    localparam logic [1:0] DSR_SPACE_IO = 2'h2;

endpackage : dsr_pkg

// ### bench/dsr_core_props.sv
// Port checker of dsr_core, bound to every instance.
// Assumes one clock domain and the map header on the include path.
`include "dsr_map.svh"
module dsr_core_props
    import dsr_pkg::*;
#(
    parameter int CH_NUM = 6
) (
    // Clock, reset and register port
    input wire logic              i_clk,
    input wire logic              i_rstn,
    input wire logic [5:0]        i_addr,
    input wire logic [15:0]       i_wdata,
    input wire logic              i_wr,
    // DMA engine side
    input wire dsr_acc_t          i_acc,
    input wire logic [CH_NUM-1:0] o_ch_go,
    input wire logic [CH_NUM-1:0] o_ch_enable,
    input wire logic [CH_NUM-1:0] o_ch_prio,
    input wire logic              o_free_run,
    input wire logic              o_acc_ext,
    // Peer subsystem
    input wire logic [15:0]       o_peer_data,
    input wire logic              o_peer_valid,
    input wire logic              i_peer_ready,
    input wire logic              o_peer_ipreq
);
    logic io_acc;
    logic ipreq_wr;
    logic prec_wr;
    assign io_acc = i_acc.req && i_acc.space == DSR_SPACE_IO;
    assign prec_wr = i_wr && i_addr == `DSR_A_PREC;
    assign ipreq_wr = i_wr && i_addr == `DSR_A_BANK_SWITCH_CONTROL_REG && i_wdata[8];
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    sequence s_prec_wr;
        prec_wr;
    endsequence
    sequence s_out_push;
        io_acc && i_acc.wr && !o_peer_valid;
    endsequence
    AST_ACC_EXT: assert property (!o_acc_ext)
        else $error("I/O access routed outside");
    AST_GO_EN: assert property ((o_ch_go & ~o_ch_enable) == '0)
        else $error("disabled channel released");
    AST_PREC_WR: assert property (s_prec_wr |=>
        o_ch_enable == $past(i_wdata[5:0]) && o_free_run == $past(i_wdata[15])
        && o_ch_prio == $past(i_wdata[13:8])) else $error("fields not taken");
    AST_PREC_HOLD: assert property (!prec_wr |=>
        $stable(o_ch_enable) && $stable(o_ch_prio) && $stable(o_free_run))
        else $error("fields changed without write");
    AST_IPREQ_SET: assert property (ipreq_wr |=> o_peer_ipreq)
        else $error("peer request missing");
    AST_IPREQ_CAUSE: assert property (o_peer_ipreq |->
        $past(ipreq_wr)) else $error("peer request without write");
    AST_OUT_FIRST: assert property (s_out_push |=> o_peer_valid
        && o_peer_data == $past(i_acc.data)) else $error("word not offered");
    AST_CPU_SPACE: assert property (i_acc.req && !io_acc
        && !o_peer_valid |=> !o_peer_valid) else $error("non I/O push");
    AST_PEER_HOLD: assert property (o_peer_valid && !i_peer_ready
        |=> o_peer_valid && $stable(o_peer_data)) else $error("word lost");
endmodule : dsr_core_props

bind dsr_core dsr_core_props #(.CH_NUM(CH_NUM)) u_props (
    .i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_acc, .o_ch_go,
    .o_ch_enable, .o_ch_prio, .o_free_run, .o_acc_ext, .o_peer_data,
    .o_peer_valid, .i_peer_ready, .o_peer_ipreq
);

// ### bench/dsr_peer_model.sv
// Peer subsystem model: feeds the input FIFO and drains the output FIFO.
// Assumes the core clock; the bench calls its tasks and sets stall.
module dsr_peer_model (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Words towards the core
    output logic      [15:0] o_data,
    output logic             o_valid,
    input  wire logic        i_ready,
    // Words from the core
    input  wire logic [15:0] i_data,
    input  wire logic        i_valid,
    output logic             o_ready,
    // Interprocessor request
    output logic             o_ipreq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        stall = 1'b0;
    logic [15:0] rx_q [$];
    initial begin
        o_data = 16'hffff;
        o_valid = 1'b0;
        o_ipreq = 1'b0;
    end
    assign o_ready = !stall;
    always @(posedge i_clk) begin
        if (i_rstn && i_valid && o_ready) begin
            rx_q.push_back(i_data);
        end
    end
    task automatic push(input logic [15:0] w, output bit ok);
        bit r;
        ok = 1'b0;
        o_valid <= 1'b1;
        o_data <= w;
        for (int k = 0; k < 40 && !ok; k++) begin
            @(negedge i_clk);
            r = i_ready;
            @(posedge i_clk);
            ok = r;
        end
        o_valid <= 1'b0;
        o_data <= ~w;
        @(posedge i_clk);
    endtask : push
    task automatic ipreq();
        o_ipreq <= 1'b1;
        @(posedge i_clk);
        o_ipreq <= 1'b0;
        @(posedge i_clk);
    endtask : ipreq
endmodule : dsr_peer_model

// ### bench/tb_dsr_core.sv
// Testbench of dsr_core with the peer model on its FIFO link.
// Assumes dsr_pkg, the map header and the checker are compiled first.
`include "dsr_map.svh"
module tb_dsr_core
    import dsr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] EV [0:6] = '{6'h00, 6'h08, 6'h01, 6'h20,
                                        6'h04, 6'h10, 6'h02};
    logic        i_clk, i_rstn, i_wr, i_rd, o_irq, o_free_run, o_acc_ext;
    logic        i_peer_valid, o_peer_ready, o_peer_valid, i_peer_ready;
    logic        i_peer_ipreq, o_peer_ipreq;
    logic [5:0]  i_addr, i_ch_done, i_ch_auto, i_ch_global, o_ch_go;
    logic [5:0]  o_ch_enable, o_ch_prio, o_ch_peer_mem;
    logic [15:0] i_wdata, o_rdata, o_acc_rdata, i_peer_data, o_peer_data;
    logic [15:0] acc_q;
    dsr_ser_t    i_ser_evt, i_ser_irq;
    dsr_acc_t    i_acc;
    int          n_mismatch = 0;
    int          n_checks = 0;
    dsr_core u_dut (
        .i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
        .i_ser_evt, .i_ser_irq, .i_ch_done, .i_ch_auto, .i_ch_global, .i_acc,
        .o_ch_go, .o_ch_enable, .o_ch_prio, .o_free_run, .o_ch_peer_mem,
        .o_acc_rdata, .o_acc_ext, .i_peer_data, .i_peer_valid, .o_peer_ready,
        .o_peer_data, .o_peer_valid, .i_peer_ready, .i_peer_ipreq,
        .o_peer_ipreq
    );
    dsr_peer_model u_peer (
        .i_clk, .i_rstn, .o_data(i_peer_data), .o_valid(i_peer_valid),
        .i_ready(o_peer_ready), .i_data(o_peer_data), .i_valid(o_peer_valid),
        .o_ready(i_peer_ready), .o_ipreq(i_peer_ipreq)
    );
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time,
                     seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr
    task automatic rc(input logic [5:0] a, input logic [15:0] e);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
        @(posedge i_clk);
    endtask : rc
    task automatic acc(input logic w, input logic [15:0] d);
        i_acc <= '{1'b1, w, DSR_SPACE_IO, d};
        @(posedge i_clk);
        i_acc <= '0;
        #1 acc_q = o_acc_rdata;
        @(posedge i_clk);
    endtask : acc
    task automatic pulse(input logic [5:0] s, input logic [5:0] d);
        i_ser_irq <= s;
        i_ch_done <= d;
        @(posedge i_clk);
        i_ser_irq <= '0;
        i_ch_done <= '0;
        @(posedge i_clk);
    endtask : pulse
    task automatic t_reset();
        rc(`DSR_A_PREC, `DSR_PREC_RESET);
        chk({o_irq, o_ch_go, o_peer_valid, o_peer_ready}, 16'h0001);
        wr(6'h3f, 16'hffff);
        rc(6'h3f, 16'h0000);
        wr(`DSR_A_PREC, 16'ha500);
        chk({o_free_run, o_ch_prio, o_ch_enable}, 16'h1940);
        rc(`DSR_A_PREC, 16'ha500);
    endtask : t_reset
    task automatic t_sync();
        logic exp_go;
        i_ch_global <= 6'h2a;
        wr(`DSR_A_PREC, 16'h003f);
        for (int c = 0; c < 16; c++) begin
            wr(`DSR_A_SYNC0, 16'(c));
            for (int k = 0; k < 2; k++) begin
                i_ser_evt <= (c < 7 ? EV[c] : 6'h00) ^ (k ? 6'h3f : 6'h00);
                @(negedge i_clk);
                exp_go = c == 0 || c == 8 || (c < 7 && !k);
                chk(o_ch_go, {5'h1f, exp_go});
                @(posedge i_clk);
            end
        end
        chk(o_ch_peer_mem, 6'h2a);
    endtask : t_sync
    task automatic t_irq();
        logic [15:0] e;
        wr(`DSR_A_IMR, 16'hffff);
        for (int s = 0; s < 4; s++) begin
            wr(`DSR_A_PREC, 16'(s << 6));
            pulse(6'h3f, 6'h00);
            e = (s != 2 ? 16'h00c0 : 16'h0) | (s == 0 ? 16'h0c00 : 16'h0);
            chk(o_irq, e != 0);
            rc(`DSR_A_IFR, e);
            pulse(6'h00, 6'h3f);
            e = 16'h3000 | (s == 2 ? 16'h00c0 : 16'h0);
            e = e | (s == 1 || s == 2 ? 16'h0c00 : 16'h0);
            rc(`DSR_A_IFR, e);
            rc(`DSR_A_IFR, 16'h0000);
        end
        wr(`DSR_A_IMR, 16'h0000);
        pulse(6'h00, 6'h30);
        chk(o_irq, 1'b0);
    endtask : t_irq
    task automatic t_reload();
        i_ch_auto <= 6'h18;
        wr(`DSR_A_REC0, 16'h0a0a);
        wr(`DSR_A_REC0 + 6'h3, 16'h0b0b);
        wr(`DSR_A_PREC, 16'h0000);
        pulse(6'h00, 6'h38);
        rc(`DSR_A_CUR0 + 6'h3, 16'h0a0a);
        rc(`DSR_A_CUR0 + 6'h5, 16'h0000);
        wr(`DSR_A_REC0 + 6'h3, 16'h0c0c);
        rc(`DSR_A_CUR0 + 6'h3, 16'h0a0a);
        wr(`DSR_A_PREC, 16'h4000);
        pulse(6'h00, 6'h18);
        rc(`DSR_A_CUR0 + 6'h3, 16'h0c0c);
        rc(`DSR_A_CUR0 + 6'h4, 16'h0000);
    endtask : t_reload
    task automatic t_fifo();
        bit ok;
        wr(`DSR_A_PREC, 16'h0003);
        wr(`DSR_A_SYNC0, 16'h0008);
        wr(`DSR_A_SYNC0 + 6'h1, 16'h0007);
        u_peer.stall <= 1'b1;
        i_acc <= '{1'b1, 1'b1, 2'h0, 16'hdead};
        @(posedge i_clk);
        i_acc <= '0;
        for (int k = 0; k < 9; k++) begin
            @(negedge i_clk);
            chk(o_ch_go[0], k < 8);
            @(posedge i_clk);
            acc(1'b1, 16'h0100 + 16'(k));
        end
        chk(o_acc_ext, 1'b0);
        u_peer.stall <= 1'b0;
        for (int k = 0; k < 30 && u_peer.rx_q.size() < 8; k++) begin
            @(posedge i_clk);
        end
        chk(u_peer.rx_q.size(), 8);
        foreach (u_peer.rx_q[k]) begin
            chk(u_peer.rx_q[k], 16'h0100 + 16'(k));
        end
        chk(o_ch_go[1], 1'b0);
        for (int k = 0; k < 3; k++) begin
            u_peer.push(16'h0a00 + 16'(k), ok);
            chk(ok, 1'b1);
        end
        for (int k = 0; k < 3; k++) begin
            @(negedge i_clk);
            chk(o_ch_go[1], 1'b1);
            @(posedge i_clk);
            acc(1'b0, 16'h0000);
            chk(acc_q, 16'h0a00 + 16'(k));
        end
        @(negedge i_clk);
        chk(o_ch_go[1], 1'b0);
        @(posedge i_clk);
    endtask : t_fifo
    task automatic t_ipreq();
        wr(`DSR_A_IMR, 16'h4000);
        wr(`DSR_A_BANK_SWITCH_CONTROL_REG, 16'h0100);
        rc(`DSR_A_BANK_SWITCH_CONTROL_REG, 16'h0000);
        rc(`DSR_A_IFR, 16'h3000);
        u_peer.ipreq();
        chk(o_irq, 1'b1);
        rc(`DSR_A_IFR, 16'h4000);
    endtask : t_ipreq
    task automatic print_verdict();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        {i_rstn, i_wr, i_rd, i_addr, i_wdata} = '0;
        {i_ch_done, i_ch_auto, i_ch_global, i_ser_evt, i_ser_irq} = '0;
        i_acc = '0;
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_sync();
        t_irq();
        t_reload();
        t_fifo();
        t_ipreq();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        print_verdict();
    end
endmodule : tb_dsr_core
